// *** common/mil_pkg.sv ***
// constants, offsets and layouts of the interrupt gathering and vectoring block
// assumes 8-bit control registers placed one per 32-bit apb word
package mil_pkg;
   // register byte offsets
   localparam logic [7:0] ctrl_off = 8'h00;
   localparam logic [7:0] pflag_a_off = 8'h04;
   localparam logic [7:0] pflag_b_off = 8'h08;
   localparam logic [7:0] pen_a_off = 8'h0c;
   localparam logic [7:0] pen_b_off = 8'h10;
   localparam logic [7:0] sts_off = 8'h14;
   localparam logic [7:0] mask_off = 8'h18;
   localparam logic [7:0] core_off = 8'h1c;
   // control register fields
   localparam int glob_en_bit = 7;
   localparam int grp_en_bit = 6;
   localparam int tmr_en_bit = 5;
   localparam int ext_en_bit = 4;
   localparam int chg_en_bit = 3;
   localparam int tmr_fl_bit = 2;
   localparam int ext_fl_bit = 1;
   localparam int chg_fl_bit = 0;
   localparam logic [7:0] ctrl_rst = 8'h00;
   localparam logic [7:0] per_rst = 8'h00;
   // event status bits
   localparam int ev_take_bit = 0;
   localparam int ev_ret_bit = 1;
   localparam int ev_w = 2;
   // vector and timing
   localparam logic [12:0] irq_vector = 13'h0004;
   localparam int quarters_per_cycle = 4;
   localparam int ext_sync_cycles = 3;
   localparam int max_sources = 12;
endpackage : mil_pkg

// *** common/mil_req_if.sv ***
// request bundle between the gather logic and the vector sequencer
// assumes a single clock domain
`timescale 1ns/1ns
interface mil_req_if;
   logic req;
   logic take;
   logic ret;
   modport gather (output req, input take, input ret);
   modport seq (input req, output take, output ret);
endinterface : mil_req_if

// *** design/mil_vector_seq.sv ***
// vector sequencer: waits for the end of an instruction cycle, then vectors
// assumes the core strobes cycle_end_i once per instruction cycle
`timescale 1ns/1ns
module mil_vector_seq #(
   parameter int pc_w = 13
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // core sequencing
   input wire logic cycle_end_i,
   input wire logic ret_instr_i,
   input wire logic [pc_w-1:0] next_pc_i,
   // gather side
   mil_req_if.seq rq,
   // outputs to the core
   output logic push_o,
   output logic [pc_w-1:0] push_addr_o,
   output logic load_pc_o,
   output logic [pc_w-1:0] pc_value_o
);
   initial begin
      if (pc_w < 13) $error("pc_w too small for vector");
   end
   typedef enum logic [0:0] {mil_idle, mil_vec} mil_st_e;
   mil_st_e st;
   // request taken at a cycle boundary; one and two cycle instructions alike
   assign rq.take = (st == mil_idle) && rq.req && cycle_end_i;
   assign rq.ret = ret_instr_i;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st <= mil_idle;
      end else begin
         case (st)
            mil_idle: if (rq.take) st <= mil_vec;
            mil_vec: st <= mil_idle;
            default: st <= mil_idle;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         push_o <= 1'b0;
         push_addr_o <= '0;
         load_pc_o <= 1'b0;
         pc_value_o <= '0;
      end else begin
         push_o <= rq.take;
         load_pc_o <= rq.take;
         if (rq.take) begin
            push_addr_o <= next_pc_i;
            pc_value_o <= pc_w'(mil_pkg::irq_vector);
         end
      end
   end
endmodule : mil_vector_seq

// *** design/mil_irq_top.sv ***
// interrupt gathering and vectoring block of an 8-bit core, apb register slave
// assumes core and peripheral event pulses synchronous to clk_i
// How it works
// - Up to nineteen sources each have a flag and an enable bit.
// - A flag is set by its event no matter which enable is set or clear.
// - Bit 7 of the control register lets unmasked requests through when set, blocks all when clear.
// - With global enable, flag and enable all set, plus group enable for peripheral sources, vectoring starts at the next instruction cycle boundary.
// - Reset clears the global enable.
// - The return instruction sets the global enable again while returning.
// - Pin, port change and timer overflow flags and enables sit in the control register.
// - Peripheral flags sit in two flag registers, enables in two enable registers, group enable in control.
// - Taking an interrupt clears global enable, pushes return address and loads the pc with 0004h.
// - Pin and port change events vector three or four instruction cycles later by phase.
// - Latency is the same for one and two cycle instructions.
`timescale 1ns/1ns
module mil_irq_top #(
   parameter int per_w = 8,
   parameter int pc_w = 13
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // apb slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   // events
   input wire logic ext_pin_edge_i,
   input wire logic port_change_i,
   input wire logic timer_ovf_i,
   input wire logic [per_w-1:0] per_event_a_i,
   input wire logic [per_w-1:0] per_event_b_i,
   // core sequencing
   input wire logic quarter_i,
   input wire logic ret_instr_i,
   input wire logic [pc_w-1:0] next_pc_i,
   // to the core
   output logic push_o,
   output logic [pc_w-1:0] push_addr_o,
   output logic load_pc_o,
   output logic [pc_w-1:0] pc_value_o,
   output logic core_req_o,
   output logic irq_o
);
   initial begin
      if (3 + 2 * per_w > mil_pkg::max_sources + 8) $error("too many sources");
   end

   mil_req_if rq ();

   logic [7:0] interrupt_control_reg;
   logic [per_w-1:0] peripheral_flags_a;
   logic [per_w-1:0] peripheral_flags_b;
   logic [per_w-1:0] peripheral_enables_a;
   logic [per_w-1:0] peripheral_enables_b;
   logic [mil_pkg::ev_w-1:0] ev_status;
   logic [mil_pkg::ev_w-1:0] ev_mask;
   logic [1:0] qcnt;
   logic cycle_end;
   logic [1:0] ext_dly;
   logic [1:0] chg_dly;
   logic ext_set;
   logic chg_set;
   logic wr_en;
   logic rd_en;
   logic global_irq_enable;
   logic peripheral_group_irq_enable;
   logic per_req;
   logic core_term;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction : hit

   // bus strobes
   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && !penable_i && !pwrite_i;
   assign pready_o = 1'b1;
   assign pslverr_o = 1'b0;

   // quarter phases form the instruction cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         qcnt <= 2'h0;
      end else if (quarter_i) begin
         qcnt <= qcnt + 2'h1;
      end
   end
   assign cycle_end = quarter_i && (qcnt == 2'(mil_pkg::quarters_per_cycle - 1));

   // external events ride a delay pipe of whole instruction cycles
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ext_dly <= 2'h0;
         chg_dly <= 2'h0;
      end else begin
         if (ext_pin_edge_i) begin
            ext_dly <= 2'h1;
         end else if (cycle_end && ext_dly != 2'h0) begin
            ext_dly <= (ext_dly == 2'(mil_pkg::ext_sync_cycles - 1)) ? 2'h0 : ext_dly + 2'h1;
         end
         if (port_change_i) begin
            chg_dly <= 2'h1;
         end else if (cycle_end && chg_dly != 2'h0) begin
            chg_dly <= (chg_dly == 2'(mil_pkg::ext_sync_cycles - 1)) ? 2'h0 : chg_dly + 2'h1;
         end
      end
   end
   // flag lands after two boundaries; the take boundary makes three or four cycles
   assign ext_set = cycle_end && ext_dly == 2'(mil_pkg::ext_sync_cycles - 1);
   assign chg_set = cycle_end && chg_dly == 2'(mil_pkg::ext_sync_cycles - 1);

   // control register: enables, flags and global enable
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         interrupt_control_reg <= mil_pkg::ctrl_rst;
      end else begin
         if (wr_en && hit(paddr_i, mil_pkg::ctrl_off)) begin
            interrupt_control_reg <= pwdata_i[7:0];
         end
         if (timer_ovf_i) interrupt_control_reg[mil_pkg::tmr_fl_bit] <= 1'b1;
         if (ext_set) interrupt_control_reg[mil_pkg::ext_fl_bit] <= 1'b1;
         if (chg_set) interrupt_control_reg[mil_pkg::chg_fl_bit] <= 1'b1;
         if (rq.ret) interrupt_control_reg[mil_pkg::glob_en_bit] <= 1'b1;
         if (rq.take) interrupt_control_reg[mil_pkg::glob_en_bit] <= 1'b0;
      end
   end

   // peripheral flag and enable registers, event set wins over write
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         peripheral_flags_a <= '0;
         peripheral_flags_b <= '0;
         peripheral_enables_a <= '0;
         peripheral_enables_b <= '0;
      end else begin
         if (wr_en && hit(paddr_i, mil_pkg::pflag_a_off)) begin
            peripheral_flags_a <= pwdata_i[per_w-1:0] | per_event_a_i;
         end else begin
            peripheral_flags_a <= peripheral_flags_a | per_event_a_i;
         end
         if (wr_en && hit(paddr_i, mil_pkg::pflag_b_off)) begin
            peripheral_flags_b <= pwdata_i[per_w-1:0] | per_event_b_i;
         end else begin
            peripheral_flags_b <= peripheral_flags_b | per_event_b_i;
         end
         if (wr_en && hit(paddr_i, mil_pkg::pen_a_off)) begin
            peripheral_enables_a <= pwdata_i[per_w-1:0];
         end
         if (wr_en && hit(paddr_i, mil_pkg::pen_b_off)) begin
            peripheral_enables_b <= pwdata_i[per_w-1:0];
         end
      end
   end

   // request combination
   assign global_irq_enable = interrupt_control_reg[mil_pkg::glob_en_bit];
   assign peripheral_group_irq_enable = interrupt_control_reg[mil_pkg::grp_en_bit];
   assign per_req = peripheral_group_irq_enable &&
      (|(peripheral_flags_a & peripheral_enables_a) ||
       |(peripheral_flags_b & peripheral_enables_b));
   assign core_term = per_req ||
      (interrupt_control_reg[mil_pkg::tmr_fl_bit] && interrupt_control_reg[mil_pkg::tmr_en_bit]) ||
      (interrupt_control_reg[mil_pkg::ext_fl_bit] && interrupt_control_reg[mil_pkg::ext_en_bit]) ||
      (interrupt_control_reg[mil_pkg::chg_fl_bit] && interrupt_control_reg[mil_pkg::chg_en_bit]);
   assign rq.req = global_irq_enable && core_term;
   assign core_req_o = rq.req;

   // event status: take and return, write one to clear, set wins
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ev_status <= '0;
         ev_mask <= '0;
      end else begin
         if (wr_en && hit(paddr_i, mil_pkg::sts_off)) begin
            ev_status <= (ev_status & ~pwdata_i[mil_pkg::ev_w-1:0]) | {rq.ret, rq.take};
         end else begin
            ev_status <= ev_status | {rq.ret, rq.take};
         end
         if (wr_en && hit(paddr_i, mil_pkg::mask_off)) begin
            ev_mask <= pwdata_i[mil_pkg::ev_w-1:0];
         end
      end
   end
   assign irq_o = |(ev_status & ev_mask);

   // read data registered in the setup cycle
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0;
      end else if (rd_en) begin
         if (hit(paddr_i, mil_pkg::ctrl_off)) begin
            prdata_o <= {24'h0, interrupt_control_reg};
         end else if (hit(paddr_i, mil_pkg::pflag_a_off)) begin
            prdata_o <= 32'(peripheral_flags_a);
         end else if (hit(paddr_i, mil_pkg::pflag_b_off)) begin
            prdata_o <= 32'(peripheral_flags_b);
         end else if (hit(paddr_i, mil_pkg::pen_a_off)) begin
            prdata_o <= 32'(peripheral_enables_a);
         end else if (hit(paddr_i, mil_pkg::pen_b_off)) begin
            prdata_o <= 32'(peripheral_enables_b);
         end else if (hit(paddr_i, mil_pkg::sts_off)) begin
            prdata_o <= 32'(ev_status);
         end else if (hit(paddr_i, mil_pkg::mask_off)) begin
            prdata_o <= 32'(ev_mask);
         end else if (hit(paddr_i, mil_pkg::core_off)) begin
            prdata_o <= {30'h0, core_term, rq.req};
         end else begin
            prdata_o <= 32'h0;
         end
      end
   end

   mil_vector_seq #(
      .pc_w(pc_w)
   ) u_seq (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cycle_end_i(cycle_end),
      .ret_instr_i(ret_instr_i),
      .next_pc_i(next_pc_i),
      .rq(rq.seq),
      .push_o(push_o),
      .push_addr_o(push_addr_o),
      .load_pc_o(load_pc_o),
      .pc_value_o(pc_value_o)
   );
endmodule : mil_irq_top

// *** verification/mil_irq_assertions.sv ***
// port checker for the interrupt gather and vector block
// assumes one clock domain, sync active high reset
`timescale 1ns/1ns
module mil_irq_assertions #(
   parameter int pc_w = 13
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // watched inputs
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic quarter_i,
   input wire logic [pc_w-1:0] next_pc_i,
   // watched outputs
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic push_o,
   input wire logic [pc_w-1:0] push_addr_o,
   input wire logic load_pc_o,
   input wire logic [pc_w-1:0] pc_value_o,
   input wire logic core_req_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_take_clears_enable: assert property (push_o |-> !core_req_o)
      else $error("request still up after take");
   a_take_needs_req: assert property ($rose(push_o) |-> $past(core_req_o && quarter_i))
      else $error("vector without enabled request");
   a_req_served: assert property (not ((core_req_o && quarter_i) [*8]))
      else $error("enabled request not vectored");
   a_return_addr: assert property (push_o |-> push_addr_o == $past(next_pc_i))
      else $error("wrong return address");
   a_vector_value: assert property (load_pc_o |-> pc_value_o == mil_pkg::irq_vector)
      else $error("wrong vector");
   a_push_load_pair: assert property (push_o |-> load_pc_o ##1 !push_o && !load_pc_o)
      else $error("push and load not one paired pulse");
   a_reset_clear: assert property (disable iff (1'b0)
      $fell(reset_i) |-> !core_req_o && !push_o && !load_pc_o)
      else $error("request or vector right after reset");
   a_apb_ready: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
      else $error("apb access not completed cleanly");
   cover property (push_o);
   cover property (push_o ##[1:60] push_o);
   cover property (psel_i && penable_i);
endmodule : mil_irq_assertions

bind mil_irq_top mil_irq_assertions #(.pc_w(pc_w)) mil_irq_assertions_inst (
   .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
   .quarter_i(quarter_i), .next_pc_i(next_pc_i), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .push_o(push_o), .push_addr_o(push_addr_o),
   .load_pc_o(load_pc_o), .pc_value_o(pc_value_o), .core_req_o(core_req_o));

// *** verification/mil_core_model.sv ***
// core sequencer model: quarter ticks, return strobe, return address
// assumes bench control changes just after rising edges
`timescale 1ns/1ns
module mil_core_model #(
   parameter int pc_w = 13
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // bench control
   input wire logic ret_req_i,
   input wire logic stall_i,
   input wire logic [pc_w-1:0] pc_i,
   // to the block
   output logic quarter_o,
   output logic ret_instr_o,
   output logic [pc_w-1:0] next_pc_o
);
   always_ff @(posedge clk_i) begin
      quarter_o <= !reset_i && !stall_i;
      ret_instr_o <= !reset_i && ret_req_i;
      next_pc_o <= pc_i;
   end
endmodule : mil_core_model

// *** verification/mil_irq_top_tb.sv ***
// self-checking bench of the interrupt block with a core model
// assumes zero wait apb slave, one clock at 125 MHz
`timescale 1ns/1ns
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin mismatches++; \
   $display("unexpected %s exp %h got %h", n, e, g); end end
module mil_irq_top_tb;
   logic clk_i = 0, reset_i = 1, psel = 0, pen = 0, pwr = 0, ext = 0, chg = 0, tmr = 0;
   logic ret_req = 0, stall = 0, pready, pslverr, push, load, core_req, irq, qt, ret_instr;
   logic [7:0] paddr = 0, pa = 0, pb = 0, m, c, en[5], fl[5];
   logic [31:0] pwdata = 0, prdata, ex;
   logic [12:0] pc = 0, push_addr, pc_val, next_pc, ev_pc;
   logic [31:0] rd_q[$];
   logic [12:0] vec_q[$];
   int mismatches = 0, check_count = 0, n, k, b;
   initial forever #4 clk_i = ~clk_i;
   mil_core_model mil_core_model_inst (.clk_i(clk_i), .reset_i(reset_i), .ret_req_i(ret_req),
      .stall_i(stall), .pc_i(pc), .quarter_o(qt), .ret_instr_o(ret_instr), .next_pc_o(next_pc));
   mil_irq_top mil_irq_top_inst (.clk_i(clk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .ext_pin_edge_i(ext), .port_change_i(chg),
      .timer_ovf_i(tmr), .per_event_a_i(pa), .per_event_b_i(pb), .quarter_i(qt),
      .ret_instr_i(ret_instr), .next_pc_i(next_pc), .push_o(push), .push_addr_o(push_addr),
      .load_pc_o(load), .pc_value_o(pc_val), .core_req_o(core_req), .irq_o(irq));
   always @(posedge clk_i) begin
      if (psel && pen && !pwr && pready === 1'b1) begin
         ex = rd_q.pop_front();
         `CHK("prdata", ex, prdata)
      end
      if (push === 1'b1) begin
         ev_pc = vec_q.pop_front();
         `CHK("push_addr", ev_pc, push_addr)
         `CHK("vector", 13'h0004, pc_val)
         `CHK("load_pc", 1'b1, load)
         `CHK("core_req", 1'b0, core_req)
      end
   end
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      psel <= 1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      pen <= 1;
      @(posedge clk_i);
      while (pready !== 1'b1) @(posedge clk_i);
      psel <= 0;
      pen <= 0;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      rd_q.push_back({24'h0, e});
      apb(0, a, 0);
   endtask : rd
   task automatic ev(input int s, input logic [7:0] v);
      @(posedge clk_i);
      case (s)
         0: ext <= 1;
         1: chg <= 1;
         2: tmr <= 1;
         3: pa <= v;
         default: pb <= v;
      endcase
      @(posedge clk_i);
      {ext, chg, tmr, pa, pb} <= '0;
   endtask : ev
   task automatic wait_push(output int cnt);
      cnt = 0;
      while (push !== 1'b1 && cnt < 40) begin
         @(posedge clk_i);
         #1;
         cnt++;
      end
      if (push !== 1'b1) mismatches++;
   endtask : wait_push
   task automatic ret;
      @(posedge clk_i);
      ret_req <= 1;
      @(posedge clk_i);
      ret_req <= 0;
   endtask : ret
   task print_verdict;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : print_verdict
   initial begin
      #400000;
      mismatches++;
      print_verdict();
   end
   initial begin
      void'($urandom(32'h8541));
      en = '{8'h10, 8'h08, 8'h20, 8'h00, 8'h00};
      fl = '{8'h02, 8'h01, 8'h04, 8'h00, 8'h00};
      repeat (6) @(posedge clk_i);
      reset_i <= 0;
      rd(mil_pkg::ctrl_off, 8'h00);
      rd(8'h20, 8'h00);
      m = 8'($urandom);
      ev(2, 0);
      ev(3, m);
      ev(4, ~m);
      rd(mil_pkg::ctrl_off, fl[2]);
      rd(mil_pkg::pflag_a_off, m);
      rd(mil_pkg::pflag_b_off, ~m);
      $display("test flags done");
      for (k = 0; k < 5; k++) begin
         {m, c} = {8'h01 << $urandom_range(7), 8'h80 | en[k]};
         pc <= 13'($urandom);
         apb(1, mil_pkg::ctrl_off, 0);
         apb(1, mil_pkg::pflag_a_off, 0);
         apb(1, mil_pkg::pflag_b_off, 0);
         apb(1, mil_pkg::pen_a_off, k == 3 ? m : 8'h00);
         apb(1, mil_pkg::pen_b_off, k == 4 ? m : 8'h00);
         rd(k == 4 ? mil_pkg::pen_b_off : mil_pkg::pen_a_off, k > 2 ? m : 8'h00);
         apb(1, mil_pkg::ctrl_off, c);
         vec_q.push_back(pc);
         ev(k, m);
         if (k > 2) begin
            repeat (16) @(posedge clk_i);
            rd(mil_pkg::ctrl_off, 8'h80);
            apb(1, mil_pkg::ctrl_off, 8'hc0);
            c = 8'h40;
         end
         wait_push(n);
         if (k < 2) `CHK("latency", 1'b1, n >= 8 && n <= 16)
         rd(mil_pkg::ctrl_off, (c & 8'h7f) | fl[k]);
         rd(mil_pkg::core_off, 8'h02);
         if (k == 2) begin
            vec_q.push_back(pc);
            ret();
            wait_push(n);
            apb(1, mil_pkg::ctrl_off, en[2]);
            ret();
            repeat (12) @(posedge clk_i);
            rd(mil_pkg::ctrl_off, 8'h80 | en[2]);
         end
         $display("test source %0d done", k);
      end
      for (b = 0; b < 2; b++) begin
         apb(1, mil_pkg::mask_off, 32'h1 << b);
         @(negedge clk_i);
         `CHK("irq", 1'b1, irq)
         apb(1, mil_pkg::sts_off, 32'h1 << b);
         @(negedge clk_i);
         `CHK("irq", 1'b0, irq)
      end
      `CHK("pending", 0, vec_q.size())
      $display("test status done");
      @(posedge clk_i);
      reset_i <= 1;
      repeat (2) @(posedge clk_i);
      reset_i <= 0;
      rd(mil_pkg::ctrl_off, 8'h00);
      rd(mil_pkg::sts_off, 8'h00);
      repeat (2) @(posedge clk_i);
      $display("test reset done");
      print_verdict();
   end
endmodule : mil_irq_top_tb
